// File: dhwp_pkg.sv
// constants, types and helpers shared by the host write port and its channel memory
// assumes a single 100 MHz core clock and fixed documented widths
package dhwp_pkg;

  localparam int CH_W = 5;
  localparam int REG_W = 2;
  localparam int CODE_W = 14;
  localparam int WORD_W = 24;
  localparam int HDR_W = 10;
  localparam int MEM_AW = CH_W + REG_W;
  localparam int MEM_DEPTH = 128;

  // serial word layout, msb first
  localparam int W_RW = 22;
  localparam int W_CH_HI = 20;
  localparam int W_CH_LO = 16;
  localparam int W_REG_HI = 15;
  localparam int W_REG_LO = 14;
  localparam int W_CODE_HI = 13;
  localparam int W_HDR_LO = 14;
  localparam logic [4:0] SPI_LAST_BIT = 5'h17;
  localparam logic [4:0] SPI_FULL = 5'h18;

  // two-wire bus
  localparam logic [4:0] I2C_ADDR_FIXED = 5'h15;
  localparam logic I2C_DIR_WRITE = 1'b0;
  localparam logic [7:0] I2C_PTR_BURST = 8'hff;
  localparam logic [4:0] I2C_LAST_CH = 5'h1f;
  localparam logic [3:0] I2C_BYTE_BITS = 4'h8;
  localparam int B_REG_HI = 7;
  localparam int B_REG_LO = 6;
  localparam int B_CODE_HI = 5;
  localparam int I2C_SCL_MAX_KHZ = 400;
  localparam int CORE_CLK_MHZ = 100;
  localparam int I2C_MIN_HALF_CYC = (CORE_CLK_MHZ * 1000) / (2 * I2C_SCL_MAX_KHZ);

  // synchroniser lanes
  localparam int SI_TOG = 0;
  localparam int SI_SDA = 1;
  localparam int SI_SCL = 2;
  localparam int SI_WR = 3;
  localparam int SI_CS = 4;
  localparam int SI_SP = 5;
  localparam int SI_SEL = 6;
  localparam int SI_AHI = 7;
  localparam int SI_ALO = 8;
  localparam int SYNC_W = 9;
  // lanes whose pins rest high: bus lines, write strobe and chip select
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 9'h01e;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_RX = 2'b01,
    I_ACK = 2'b10,
    I_SKIP = 2'b11
  } dhwp_i2c_state_t;

  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_PTR = 2'b01,
    PH_HI = 2'b10,
    PH_LO = 2'b11
  } dhwp_phase_t;

  function automatic logic [MEM_AW-1:0] mem_addr(input logic [CH_W-1:0] ch,
                                                 input logic [REG_W-1:0] rs);
    mem_addr = {ch, rs};
  endfunction

endpackage

// File: dhwp_chan_mem.sv
// channel register store: one write port, one read port with registered data
// assumes writes and reads come from the core clock domain
`timescale 1ns/1ns
`default_nettype none
module dhwp_chan_mem
  import dhwp_pkg::*;
(
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [CODE_W-1:0] wr_data,
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [CODE_W-1:0] rd_data
);

  logic [CODE_W-1:0] mem [MEM_DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule
`default_nettype wire

// File: dhwp_top.sv
// host write port: framed serial link with readback, receive-only two-wire slave,
// parallel strobe port, all loading one channel register store
// assumes pins arrive asynchronously; the serial link clock is its own domain
//
// Contract
// - serial word with read bit set is a read request; data bits ignored.
// - next serial frame shifts out the register chosen by the previous request.
// - readback word holds 14-bit contents plus the request's upper 10 bits.
// - frame select frames readback; output changes on rising, sampled falling.
// - with clock idling high, first readback bit appears at frame select fall.
// - two-wire side is slave only, never drives clock, up to 400 kHz.
// - slave address is 10101 followed by the two strap inputs.
// - start is data falling with clock high, stop is data rising.
// - repeated start keeps the bus active and opens a new address phase.
// - each received byte of a matched transfer is acknowledged by data low in the ninth clock.
// - only a matching address with write direction zero is acknowledged.
// - without stop, a further pointer and data pair update another channel.
// - stop at any point ends the sequence and returns to waiting.
// - pointer all ones starts burst at channel 0 with auto increment.
// - burst writes each pair to the current channel, reverts after channel 31.
// - burst takes register select from the data bytes; no toggle select.
// - serial select low enables the parallel port and disables both serial.
// - write strobe rising with chip select low loads the addressed register.
// - parallel code bus is a straight 14-bit word, bit 13 most significant.
// - serial word is 24 bits: toggle, rw, zero, channel, register, code.
`timescale 1ns/1ns
`default_nettype none
module dhwp_top
  import dhwp_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic SERIAL_PARALLEL_SELECT,
  input wire logic SERIAL_PROTOCOL_SELECT,
  input wire logic SLAVE_ADDR_STRAP_HI,
  input wire logic SLAVE_ADDR_STRAP_LO,
  input wire logic SPI_SCLK,
  input wire logic SPI_SYNC_N,
  input wire logic SPI_DIN,
  output logic SPI_SDO,
  input wire logic I2C_SCL,
  input wire logic I2C_SDA_I,
  output logic I2C_SDA_O,
  output logic I2C_SDA_OE,
  input wire logic PAR_CS_N,
  input wire logic PAR_WR_N,
  input wire logic [CH_W-1:0] PAR_CHANNEL_ADDRESS_BITS,
  input wire logic PAR_REGISTER_SELECT_HI,
  input wire logic PAR_REGISTER_SELECT_LO,
  input wire logic [CODE_W-1:0] PAR_CODE_BITS,
  output logic CH_WR_STB,
  output logic [CH_W-1:0] CH_WR_CHAN,
  output logic [REG_W-1:0] CH_WR_REG,
  output logic [CODE_W-1:0] CH_WR_CODE
);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic [SYNC_W-1:0] s3;
    logic [SYNC_W-1:0] filt;
    dhwp_i2c_state_t ist;
    dhwp_phase_t ph;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic [7:0] hi;
    logic burst;
    logic [CH_W-1:0] ptr;
    logic wr_stb;
    logic [CH_W-1:0] wr_ch;
    logic [REG_W-1:0] wr_reg;
    logic [CODE_W-1:0] wr_code;
    logic rd_pend;
    logic [HDR_W-1:0] rd_hdr;
    logic [WORD_W-1:0] rb_word;
  } dhwp_state_t;

  dhwp_state_t st_ff;
  dhwp_state_t nxt_st;

  // ---------------- serial link clock domain ----------------
  logic [4:0] spi_cnt_ff;
  logic [WORD_W-2:0] spi_sh_ff;
  logic [WORD_W-1:0] spi_word_ff;
  logic spi_tog_ff;
  logic spi_rise_seen_ff;
  logic spi_out_ff;
  logic [4:0] spi_idx;

  // bit counter restarts whenever the frame is released
  always_ff @(negedge SPI_SCLK or posedge SPI_SYNC_N) begin
    if (SPI_SYNC_N) begin
      spi_cnt_ff <= 5'h00;
      spi_sh_ff <= '0;
    end else if (spi_cnt_ff != SPI_FULL) begin
      spi_cnt_ff <= spi_cnt_ff + 5'h01;
      spi_sh_ff <= {spi_sh_ff[WORD_W-3:0], SPI_DIN};
    end
  end

  // completed word is held until the next full frame; a toggle announces it
  always_ff @(negedge SPI_SCLK or negedge RST_N) begin
    if (!RST_N) begin
      spi_word_ff <= '0;
      spi_tog_ff <= 1'b0;
    end else if (!SPI_SYNC_N && spi_cnt_ff == SPI_LAST_BIT) begin
      spi_word_ff <= {spi_sh_ff, SPI_DIN};
      spi_tog_ff <= ~spi_tog_ff;
    end
  end

  assign spi_idx = SPI_LAST_BIT - spi_cnt_ff;

  // readback bits change on the rising link clock
  always_ff @(posedge SPI_SCLK or posedge SPI_SYNC_N) begin
    if (SPI_SYNC_N) begin
      spi_rise_seen_ff <= 1'b0;
      spi_out_ff <= 1'b0;
    end else begin
      spi_rise_seen_ff <= 1'b1;
      spi_out_ff <= (spi_cnt_ff < SPI_FULL) ? st_ff.rb_word[spi_idx] : 1'b0;
    end
  end

  // before the first rising edge the top bit is already presented
  assign SPI_SDO = spi_rise_seen_ff ? spi_out_ff : st_ff.rb_word[WORD_W-1];

  // ---------------- core clock domain ----------------
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] chg;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;
  logic i2c_on;
  logic spi_on;
  logic par_on;
  logic i2c_start;
  logic i2c_stop;
  logic byte_done;
  logic addr_match;
  logic [MEM_AW-1:0] rd_addr;
  logic [CODE_W-1:0] mem_q;

  assign sync_in[SI_TOG] = spi_tog_ff;
  assign sync_in[SI_SDA] = I2C_SDA_I;
  assign sync_in[SI_SCL] = I2C_SCL;
  assign sync_in[SI_WR] = PAR_WR_N;
  assign sync_in[SI_CS] = PAR_CS_N;
  assign sync_in[SI_SP] = SERIAL_PARALLEL_SELECT;
  assign sync_in[SI_SEL] = SERIAL_PROTOCOL_SELECT;
  assign sync_in[SI_AHI] = SLAVE_ADDR_STRAP_HI;
  assign sync_in[SI_ALO] = SLAVE_ADDR_STRAP_LO;

  // a lane changes once stages two and three agree on a new level
  assign chg = ~(st_ff.s2 ^ st_ff.s3) & (st_ff.s3 ^ st_ff.filt);
  assign rise = chg & st_ff.s3;
  assign fall = chg & ~st_ff.s3;

  assign i2c_on = st_ff.filt[SI_SP] & st_ff.filt[SI_SEL];
  assign spi_on = st_ff.filt[SI_SP] & ~st_ff.filt[SI_SEL];
  assign par_on = ~st_ff.filt[SI_SP];

  assign i2c_start = fall[SI_SDA] & st_ff.filt[SI_SCL];
  assign i2c_stop = rise[SI_SDA] & st_ff.filt[SI_SCL];
  assign byte_done = (st_ff.ist == I_RX) && fall[SI_SCL] && (st_ff.bcnt == I2C_BYTE_BITS);
  assign addr_match = (st_ff.sh[7:1] == {I2C_ADDR_FIXED, st_ff.filt[SI_AHI],
                       st_ff.filt[SI_ALO]}) && (st_ff.sh[0] == I2C_DIR_WRITE);

  assign rd_addr = mem_addr(spi_word_ff[W_CH_HI:W_CH_LO], spi_word_ff[W_REG_HI:W_REG_LO]);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.s1 = sync_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.filt = st_ff.filt ^ chg;
    nxt_st.wr_stb = 1'b0;
    nxt_st.rd_pend = 1'b0;

    if (st_ff.rd_pend) begin
      nxt_st.rb_word = {st_ff.rd_hdr, mem_q};
    end

    // framed serial words
    if (chg[SI_TOG] && spi_on) begin
      if (spi_word_ff[W_RW]) begin
        nxt_st.rd_pend = 1'b1;
        nxt_st.rd_hdr = spi_word_ff[WORD_W-1:W_HDR_LO];
      end else begin
        nxt_st.wr_stb = 1'b1;
        nxt_st.wr_ch = spi_word_ff[W_CH_HI:W_CH_LO];
        nxt_st.wr_reg = spi_word_ff[W_REG_HI:W_REG_LO];
        nxt_st.wr_code = spi_word_ff[W_CODE_HI:0];
      end
    end

    // parallel strobe
    if (rise[SI_WR] && !st_ff.filt[SI_CS] && par_on) begin
      nxt_st.wr_stb = 1'b1;
      nxt_st.wr_ch = PAR_CHANNEL_ADDRESS_BITS;
      nxt_st.wr_reg = {PAR_REGISTER_SELECT_HI, PAR_REGISTER_SELECT_LO};
      nxt_st.wr_code = PAR_CODE_BITS;
    end

    // two-wire receiver
    if (!i2c_on) begin
      nxt_st.ist = I_IDLE;
      nxt_st.burst = 1'b0;
    end else if (i2c_start) begin
      nxt_st.ist = I_RX;
      nxt_st.ph = PH_ADDR;
      nxt_st.bcnt = 4'h0;
      nxt_st.burst = 1'b0;
    end else if (i2c_stop) begin
      nxt_st.ist = I_IDLE;
      nxt_st.burst = 1'b0;
    end else begin
      unique case (st_ff.ist)
        I_IDLE: begin
        end
        I_SKIP: begin
        end
        I_ACK: begin
          if (fall[SI_SCL]) begin
            nxt_st.ist = I_RX;
            nxt_st.bcnt = 4'h0;
          end
        end
        I_RX: begin
          if (rise[SI_SCL] && st_ff.bcnt != I2C_BYTE_BITS) begin
            nxt_st.sh = {st_ff.sh[6:0], st_ff.filt[SI_SDA]};
            nxt_st.bcnt = st_ff.bcnt + 4'h1;
          end else if (byte_done) begin
            nxt_st.ist = I_ACK;
            unique case (st_ff.ph)
              PH_ADDR: begin
                if (addr_match) begin
                  nxt_st.ph = PH_PTR;
                end else begin
                  nxt_st.ist = I_SKIP;
                end
              end
              PH_PTR: begin
                nxt_st.ph = PH_HI;
                if (st_ff.sh == I2C_PTR_BURST) begin
                  nxt_st.burst = 1'b1;
                  nxt_st.ptr = '0;
                end else begin
                  nxt_st.burst = 1'b0;
                  nxt_st.ptr = st_ff.sh[CH_W-1:0];
                end
              end
              PH_HI: begin
                nxt_st.hi = st_ff.sh;
                nxt_st.ph = PH_LO;
              end
              PH_LO: begin
                nxt_st.wr_stb = 1'b1;
                nxt_st.wr_ch = st_ff.ptr;
                nxt_st.wr_reg = st_ff.hi[B_REG_HI:B_REG_LO];
                nxt_st.wr_code = {st_ff.hi[B_CODE_HI:0], st_ff.sh};
                nxt_st.ph = PH_PTR;
                if (st_ff.burst) begin
                  if (st_ff.ptr == I2C_LAST_CH) begin
                    nxt_st.burst = 1'b0;
                  end else begin
                    nxt_st.ptr = st_ff.ptr + 5'h01;
                    nxt_st.ph = PH_HI;
                  end
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      st_ff <= '0;
      {st_ff.s1, st_ff.s2, st_ff.s3, st_ff.filt} <= {4{SYNC_IDLE}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  dhwp_chan_mem u_mem (
    .clk(CORE_CLK),
    .wr_en(st_ff.wr_stb),
    .wr_addr(mem_addr(st_ff.wr_ch, st_ff.wr_reg)),
    .wr_data(st_ff.wr_code),
    .rd_addr(rd_addr),
    .rd_data(mem_q)
  );

  // only the data line is ever pulled; the clock line is input only
  assign I2C_SDA_O = 1'b0;
  assign I2C_SDA_OE = (st_ff.ist == I_ACK);
  assign CH_WR_STB = st_ff.wr_stb;
  assign CH_WR_CHAN = st_ff.wr_ch;
  assign CH_WR_REG = st_ff.wr_reg;
  assign CH_WR_CODE = st_ff.wr_code;

  // ---------------- checks ----------------
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_ptr_burst;
    byte_done && i2c_on && !i2c_start && !i2c_stop && st_ff.ph == PH_PTR
      && st_ff.sh == I2C_PTR_BURST;
  endsequence

  sequence s_lo_byte;
    byte_done && i2c_on && !i2c_start && !i2c_stop && st_ff.ph == PH_LO;
  endsequence

  a_start_new_addr: assert property (i2c_on && i2c_start |=>
    st_ff.ist == I_RX && st_ff.ph == PH_ADDR && st_ff.bcnt == 4'h0)
    else $error("start did not open an address phase");

  a_stop_to_idle: assert property (i2c_on && !i2c_start && i2c_stop |=>
    st_ff.ist == I_IDLE && !st_ff.burst)
    else $error("stop did not return to idle");

  a_ack_holds_low: assert property ($rose(I2C_SDA_OE) |->
    $past(st_ff.ist) == I_RX && $past(st_ff.bcnt) == I2C_BYTE_BITS && !I2C_SDA_O)
    else $error("acknowledge not after a full byte");

  a_addr_reject: assert property (byte_done && i2c_on && !i2c_start && !i2c_stop
    && st_ff.ph == PH_ADDR && !addr_match |=> st_ff.ist == I_SKIP ##1 !I2C_SDA_OE)
    else $error("foreign address acknowledged");

  a_burst_start: assert property (s_ptr_burst |=>
    st_ff.burst && st_ff.ptr == 5'h00 && st_ff.ph == PH_HI)
    else $error("burst pointer did not start at channel 0");

  a_burst_wrap: assert property (s_lo_byte ##0 (st_ff.burst && st_ff.ptr == I2C_LAST_CH) |=>
    !st_ff.burst && st_ff.ph == PH_PTR && CH_WR_STB && CH_WR_CHAN == I2C_LAST_CH)
    else $error("burst did not end after last channel");

  a_i2c_write: assert property (s_lo_byte |=> CH_WR_STB &&
    CH_WR_CODE == {$past(st_ff.hi[B_CODE_HI:0]), $past(st_ff.sh)}
    && CH_WR_REG == $past(st_ff.hi[B_REG_HI:B_REG_LO]))
    else $error("two-wire data pair stored wrongly");

  a_par_write: assert property (rise[SI_WR] && !st_ff.filt[SI_CS] && par_on |=>
    CH_WR_STB && CH_WR_CODE == $past(PAR_CODE_BITS)
    && CH_WR_CHAN == $past(PAR_CHANNEL_ADDRESS_BITS))
    else $error("parallel strobe not loaded");

  a_serial_off: assert property (!i2c_on |=> st_ff.ist == I_IDLE ##0 !I2C_SDA_OE)
    else $error("two-wire side active while disabled");

  a_rb_header: assert property (chg[SI_TOG] && spi_on && spi_word_ff[W_RW] |->
    ##2 (st_ff.rb_word[WORD_W-1:W_HDR_LO] == $past(spi_word_ff[WORD_W-1:W_HDR_LO], 2)))
    else $error("readback header not taken from request");

  a_read_no_write: assert property (chg[SI_TOG] && spi_on && spi_word_ff[W_RW]
    && !par_on |=> !CH_WR_STB)
    else $error("read request wrote a register");

endmodule
`default_nettype wire

// File: dhwp_host_i2c.sv
// two-wire bus master model: makes the bus clock, pulls data low or releases it
// assumes a pull-up on the data line; moves only at core clock falling edges
`timescale 1ns/1ns
`default_nettype none
module dhwp_host_i2c #(
  parameter int HALF = 126
) (
  input wire logic clk,
  input wire logic sda_o,
  input wire logic sda_oe,
  output var logic scl,
  output logic sda
);
  logic pull_low = 1'b0;
  initial scl = 1'b1;
  // pull-up wins when nobody pulls
  assign sda = pull_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);
  task automatic half();
    repeat (HALF) @(negedge clk);
  endtask
  task automatic start();
    pull_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    pull_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    pull_low = 1'b0;
    half();
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      half();
      pull_low = ~b[i];
      half();
      scl = 1'b1;
      half();
      scl = 1'b0;
    end
    half();
    pull_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    ack = ~sda;
    scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dac_host_write_port_test.sv
// self-checking bench: parallel, framed serial and two-wire writes plus serial readback
// assumes the write port and its partner model; a queue model predicts every write
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dac_host_write_port_test;
  import dhwp_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b1;
  logic SERIAL_PARALLEL_SELECT = 1'b0, SERIAL_PROTOCOL_SELECT = 1'b0;
  logic SLAVE_ADDR_STRAP_HI = 1'b0, SLAVE_ADDR_STRAP_LO = 1'b0;
  logic SPI_SCLK = 1'b0, SPI_SYNC_N = 1'b0, SPI_DIN = 1'b0;
  logic PAR_CS_N = 1'b1, PAR_WR_N = 1'b1;
  logic PAR_REGISTER_SELECT_HI = 1'b0, PAR_REGISTER_SELECT_LO = 1'b0;
  logic [CH_W-1:0] PAR_CHANNEL_ADDRESS_BITS = 5'h00;
  logic [CODE_W-1:0] PAR_CODE_BITS = 14'h0000;
  logic SPI_SDO, I2C_SCL, I2C_SDA_I, I2C_SDA_O, I2C_SDA_OE, CH_WR_STB, sdo_first;
  logic [CH_W-1:0] CH_WR_CHAN;
  logic [REG_W-1:0] CH_WR_REG;
  logic [CODE_W-1:0] CH_WR_CODE;
  int fails = 0;
  int checks_done = 0;
  logic [20:0] exp_q[$], got_q[$];
  int mem_m[int];

  initial begin
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  dhwp_top dut_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
    .SERIAL_PARALLEL_SELECT(SERIAL_PARALLEL_SELECT),
    .SERIAL_PROTOCOL_SELECT(SERIAL_PROTOCOL_SELECT),
    .SLAVE_ADDR_STRAP_HI(SLAVE_ADDR_STRAP_HI), .SLAVE_ADDR_STRAP_LO(SLAVE_ADDR_STRAP_LO),
    .SPI_SCLK(SPI_SCLK), .SPI_SYNC_N(SPI_SYNC_N), .SPI_DIN(SPI_DIN), .SPI_SDO(SPI_SDO),
    .I2C_SCL(I2C_SCL), .I2C_SDA_I(I2C_SDA_I), .I2C_SDA_O(I2C_SDA_O),
    .I2C_SDA_OE(I2C_SDA_OE), .PAR_CS_N(PAR_CS_N), .PAR_WR_N(PAR_WR_N),
    .PAR_CHANNEL_ADDRESS_BITS(PAR_CHANNEL_ADDRESS_BITS),
    .PAR_REGISTER_SELECT_HI(PAR_REGISTER_SELECT_HI),
    .PAR_REGISTER_SELECT_LO(PAR_REGISTER_SELECT_LO), .PAR_CODE_BITS(PAR_CODE_BITS),
    .CH_WR_STB(CH_WR_STB), .CH_WR_CHAN(CH_WR_CHAN), .CH_WR_REG(CH_WR_REG),
    .CH_WR_CODE(CH_WR_CODE));

  dhwp_host_i2c host_u (.clk(CORE_CLK), .sda_o(I2C_SDA_O), .sda_oe(I2C_SDA_OE),
    .scl(I2C_SCL), .sda(I2C_SDA_I));

  always @(posedge CORE_CLK) begin
    if (CH_WR_STB === 1'b1) got_q.push_back({CH_WR_CHAN, CH_WR_REG, CH_WR_CODE});
  end

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic expect_wr(int ch, int rg, int code);
    mem_m[ch * 4 + rg] = code;
    exp_q.push_back({ch[4:0], rg[1:0], code[13:0]});
  endtask

  task automatic check_writes(string name);
    int n = 0;
    while (got_q.size() < exp_q.size() && n < 300) begin
      @(negedge CORE_CLK);
      n++;
    end
    repeat (20) @(negedge CORE_CLK);
    `CHK(got_q.size(), exp_q.size())
    foreach (exp_q[i]) if (i < got_q.size()) `CHK(got_q[i], exp_q[i])
    exp_q.delete();
    got_q.delete();
    if (n >= 300) begin
      fails++;
      report_and_stop();
    end
    $display("test %s done", name);
  endtask

  task automatic par_wr(int ch, int rg, int code, logic cs_n);
    @(negedge CORE_CLK);
    PAR_CS_N = cs_n;
    PAR_CHANNEL_ADDRESS_BITS = ch[4:0];
    {PAR_REGISTER_SELECT_HI, PAR_REGISTER_SELECT_LO} = rg[1:0];
    PAR_CODE_BITS = code[13:0];
    PAR_WR_N = 1'b0;
    repeat (6) @(negedge CORE_CLK);
    PAR_WR_N = 1'b1;
    repeat (8) @(negedge CORE_CLK);
    PAR_CS_N = 1'b1;
  endtask

  // link clock runs only inside the frame, 6 ns period, idles low
  task automatic spi_frame(input logic [23:0] w, output logic [23:0] rd);
    @(negedge CORE_CLK);
    SPI_SYNC_N = 1'b0;
    #4;
    sdo_first = SPI_SDO;
    for (int i = 23; i >= 0; i--) begin
      SPI_SCLK = 1'b1;
      SPI_DIN = w[i];
      #3;
      rd[i] = SPI_SDO;
      SPI_SCLK = 1'b0;
      #3;
    end
    SPI_SYNC_N = 1'b1;
    repeat (20) @(negedge CORE_CLK);
  endtask

  task automatic i2c_tx(logic [7:0] b, logic exp_ack);
    logic ack;
    host_u.send_byte(b, ack);
    `CHK(ack, exp_ack)
  endtask

  task automatic i2c_pair(int ch, int rg, int code);
    i2c_tx({rg[1:0], code[13:8]}, 1'b1);
    i2c_tx(code[7:0], 1'b1);
    expect_wr(ch, rg, code);
  endtask

  initial begin
    int ch, rg, code, pch, prg;
    logic [23:0] req, req2, rd;
    logic [6:0] addr;
    void'($urandom(32'h0be5));
    // real edges so the link-side flops leave their unknown start state
    @(negedge CORE_CLK);
    RST_N = 1'b0;
    SPI_SYNC_N = 1'b1;
    repeat (20) @(negedge CORE_CLK);
    RST_N = 1'b1;
    repeat (10) @(negedge CORE_CLK);
    for (int k = 0; k < 4; k++) begin
      pch = $urandom % 32;
      prg = $urandom % 4;
      code = $urandom % 16384;
      par_wr(pch, prg, code, 1'b0);
      expect_wr(pch, prg, code);
    end
    par_wr(3, 1, 14'h1555, 1'b1);
    check_writes("parallel");
    SERIAL_PARALLEL_SELECT = 1'b1;
    repeat (10) @(negedge CORE_CLK);
    par_wr(4, 2, 14'h2aaa, 1'b0);
    check_writes("serial_blocks_parallel");
    ch = 1 + $urandom % 31;
    rg = $urandom % 4;
    code = $urandom % 16384;
    spi_frame({2'h0, 1'b0, ch[4:0], rg[1:0], code[13:0]}, rd);
    expect_wr(ch, rg, code);
    check_writes("spi_write");
    req = {2'h3, 1'b0, ch[4:0], rg[1:0], 14'h3fff};
    req2 = {2'h1, 1'b0, pch[4:0], prg[1:0], 14'h0000};
    spi_frame(req, rd);
    spi_frame(req2, rd);
    `CHK(rd, {req[23:14], 14'(mem_m[ch * 4 + rg])})
    `CHK(sdo_first, req[23])
    spi_frame(24'h000000, rd);
    `CHK(rd, {req2[23:14], 14'(mem_m[pch * 4 + prg])})
    expect_wr(0, 0, 0);
    check_writes("spi_readback");
    SERIAL_PROTOCOL_SELECT = 1'b1;
    {SLAVE_ADDR_STRAP_HI, SLAVE_ADDR_STRAP_LO} = 2'($urandom);
    repeat (10) @(negedge CORE_CLK);
    addr = {I2C_ADDR_FIXED, SLAVE_ADDR_STRAP_HI, SLAVE_ADDR_STRAP_LO};
    host_u.start();
    i2c_tx({addr, I2C_DIR_WRITE}, 1'b1);
    for (int k = 0; k < 2; k++) begin
      ch = $urandom % 32;
      i2c_tx({3'h0, ch[4:0]}, 1'b1);
      i2c_pair(ch, $urandom % 4, $urandom % 16384);
    end
    host_u.stop();
    check_writes("i2c_three_byte");
    host_u.start();
    i2c_tx({addr ^ 7'h01, 1'b0}, 1'b0);
    i2c_tx(8'h05, 1'b0);
    host_u.stop();
    host_u.start();
    i2c_tx({addr, 1'b1}, 1'b0);
    host_u.stop();
    check_writes("i2c_refused");
    host_u.start();
    i2c_tx({addr, 1'b0}, 1'b1);
    i2c_tx(I2C_PTR_BURST, 1'b1);
    for (int k = 0; k < 2; k++) i2c_pair(k, $urandom % 4, $urandom % 16384);
    host_u.start();
    i2c_tx({addr, 1'b0}, 1'b1);
    i2c_tx(8'h1f, 1'b1);
    i2c_pair(31, 2, 14'h2c3d);
    host_u.stop();
    check_writes("i2c_burst");
    report_and_stop();
  end
endmodule
`default_nettype wire
